//--- hdl/cca_map.vh
`ifndef CCA_MAP_VH
`define CCA_MAP_VH
// special function register addresses
`define CCA_ADDR_CTRL     8'hd8
`define CCA_ADDR_AMODE    8'hd9
`define CCA_ADDR_MODE0    8'hda
`define CCA_ADDR_CNTL     8'he9
`define CCA_ADDR_CMPL0    8'hea
`define CCA_ADDR_CNTH     8'hf9
`define CCA_ADDR_CMPH0    8'hfa
// module mode register fields
`define CCA_MODE_COMPARE_ENABLE     6
`define CCA_MODE_RISE     5
`define CCA_MODE_FALL     4
`define CCA_MODE_HIT      3
`define CCA_MODE_FLIP     2
`define CCA_MODE_DUTY     1
`define CCA_MODE_IRQ      0
// array control register fields
`define CCA_CTRL_OVF      7
`define CCA_CTRL_RUN      6
// array mode register fields
`define CCA_AMODE_IDLE    7
`define CCA_AMODE_WDOG    6
`define CCA_AMODE_OVFIE   0
`define CCA_AMODE_MASK    8'hc7
// reset values and counter maxima
`define CCA_RST_BYTE      8'h00
`define CCA_RST_MODE      7'h00
`define CCA_RST_PIN       1'b1
`define CCA_CNT_MAX       16'hffff
`define CCA_CNTL_MAX      8'hff
`endif

//--- hdl/cca_unit.v
`timescale 1ns/10ps
`include "cca_map.vh"
// one compare/capture module on the shared counter
module cca_unit (
	// clock and reset
	input  wire        clock,
	input  wire        rst,
	// register writes
	input  wire [7:0]  wdata,
	input  wire        wr_mode,
	input  wire        wr_low,
	input  wire        wr_high,
	input  wire        wr_flag,
	input  wire        flag_d,
	// shared counter
	input  wire [15:0] cnt,
	input  wire        step,
	input  wire        wrap,
	// filtered pin level
	input  wire        pin_lvl,
	// state
	output reg  [6:0]  mode_r,
	output reg  [7:0]  cmp_low_r,
	output reg  [7:0]  cmp_high_r,
	output reg         flag_r,
	output reg         pin_out_r,
	output reg         pin_oe_n_r,
	output wire        hit
);
	reg        lvl_d_r;
	wire       compare_enable   = mode_r[`CCA_MODE_COMPARE_ENABLE];
	wire       rise   = pin_lvl & ~lvl_d_r;
	wire       fall   = ~pin_lvl & lvl_d_r;
	wire       grab   = (mode_r[`CCA_MODE_RISE] & rise) | (mode_r[`CCA_MODE_FALL] & fall);
	wire       pwm_on = mode_r[`CCA_MODE_DUTY] & compare_enable;
	wire       hso_on = mode_r[`CCA_MODE_FLIP] & mode_r[`CCA_MODE_HIT] & compare_enable;

	// match only on a fresh counter value, so one value fires once
	assign hit = step & compare_enable & (cnt == {cmp_high_r, cmp_low_r});

	// edge detect on successive filtered samples
	always @(posedge clock) begin
		if (rst) begin
			lvl_d_r <= `CCA_RST_PIN; // idle level of a pulled-up pin, so no edge follows reset
		end else begin
			lvl_d_r <= pin_lvl;
		end
	end

	// mode and compare bytes, with write side effects on enable
	always @(posedge clock) begin
		if (rst) begin
			mode_r     <= `CCA_RST_MODE;
			cmp_low_r  <= `CCA_RST_BYTE;
			cmp_high_r <= `CCA_RST_BYTE;
		end else begin
			if (wr_mode)
				mode_r <= wdata[6:0];
			else if (wr_low)
				mode_r[`CCA_MODE_COMPARE_ENABLE] <= 1'b0;
			else if (wr_high)
				mode_r[`CCA_MODE_COMPARE_ENABLE] <= 1'b1;
			if (grab)
				{cmp_high_r, cmp_low_r} <= cnt;
			else begin
				if (wr_low)
					cmp_low_r <= wdata;
				else if (wrap & pwm_on)
					cmp_low_r <= cmp_high_r;
				if (wr_high)
					cmp_high_r <= wdata;
			end
		end
	end

	// event flag: hardware set beats software write
	always @(posedge clock) begin
		if (rst) begin
			flag_r <= 1'b0;
		end else if (grab | (hit & mode_r[`CCA_MODE_HIT])) begin
			flag_r <= 1'b1;
		end else if (wr_flag) begin
			flag_r <= flag_d;
		end
	end

	// pin drive: duty compare or toggle on match, else released
	always @(posedge clock) begin
		if (rst) begin
			pin_out_r  <= `CCA_RST_PIN;
			pin_oe_n_r <= 1'b1;
		end else begin
			pin_oe_n_r <= ~(pwm_on | hso_on);
			if (pwm_on)
				pin_out_r <= (cnt[7:0] >= cmp_low_r);
			else if (hso_on & hit)
				pin_out_r <= ~pin_out_r;
		end
	end
endmodule

//--- hdl/cca_top.v
`timescale 1ns/10ps
`include "cca_map.vh"
module cca_top #(
	parameter NUM_UNITS = 5
) (
	// clock and reset
	clock,
	rst,
	// special function register port
	sfr_addr,
	sfr_wdata,
	sfr_wr,
	sfr_rd,
	sfr_rdata_r,
	// counter time base
	count_tick,
	cpu_idle,
	// module pins
	pin_in,
	pin_out_r,
	pin_oe_n_r,
	// system outputs
	irq_r,
	wdog_reset_r
);
	// *********************************************
	// ports
	// *********************************************
	input  wire                 clock;
	input  wire                 rst;
	input  wire [7:0]           sfr_addr;
	input  wire [7:0]           sfr_wdata;
	input  wire                 sfr_wr;
	input  wire                 sfr_rd;
	output reg  [7:0]           sfr_rdata_r;
	input  wire                 count_tick;
	input  wire                 cpu_idle;
	input  wire [NUM_UNITS-1:0] pin_in;
	output reg  [NUM_UNITS-1:0] pin_out_r;
	output reg  [NUM_UNITS-1:0] pin_oe_n_r;
	output reg                  irq_r;
	output reg                  wdog_reset_r;

	// watchdog lives on the last module only
	localparam WDOG_UNIT = NUM_UNITS - 1;

	// *********************************************
	// address decode
	// *********************************************
	// true when addr selects entry n of a bank starting at base
	function is_slot;
		input [7:0] addr;
		input [7:0] base;
		input [7:0] n;
		begin
			is_slot = (addr == (base + n));
		end
	endfunction

	// true when addr falls inside a bank of NUM_UNITS entries
	function in_bank;
		input [7:0] addr;
		input [7:0] base;
		reg   [7:0] off;
		begin
			off = addr - base;
			in_bank = (addr >= base) && (off < NUM_UNITS);
		end
	endfunction

	// *********************************************
	// declarations
	// *********************************************
	reg  [15:0]            cnt_r;
	reg                    step_r;
	reg                    wrap_r;
	reg                    ovf_r;
	reg                    run_r;
	reg  [7:0]             amode_r;
	reg  [NUM_UNITS-1:0]   sync1_r;
	reg  [NUM_UNITS-1:0]   sync2_r;
	reg  [NUM_UNITS-1:0]   sync3_r;
	reg  [NUM_UNITS-1:0]   lvl_r;
	reg  [7:0]             rd_nxt;
	reg  [7:0]             off_rd;
	wire [NUM_UNITS*7-1:0] mode_all;
	wire [NUM_UNITS*8-1:0] cmpl_all;
	wire [NUM_UNITS*8-1:0] cmph_all;
	wire [NUM_UNITS-1:0]   flag_all;
	wire [NUM_UNITS-1:0]   out_all;
	wire [NUM_UNITS-1:0]   oe_n_all;
	wire [NUM_UNITS-1:0]   hit_all;
	wire [NUM_UNITS-1:0]   irq_en_all;
	wire                   wr_ctrl  = sfr_wr & (sfr_addr == `CCA_ADDR_CTRL);
	wire                   wr_amode = sfr_wr & (sfr_addr == `CCA_ADDR_AMODE);
	wire                   wr_cntl  = sfr_wr & (sfr_addr == `CCA_ADDR_CNTL);
	wire                   wr_cnth  = sfr_wr & (sfr_addr == `CCA_ADDR_CNTH);
	// counting pauses in idle only when software asked for it
	wire                   advance  = count_tick & run_r &
	                                  ~(cpu_idle & amode_r[`CCA_AMODE_IDLE]);
	wire                   full     = (cnt_r == `CCA_CNT_MAX);

	// *********************************************
	// pin synchronisers
	// *********************************************
	// three stages; level accepted once stages two and three agree
	always @(posedge clock) begin
		if (rst) begin
			sync1_r <= {NUM_UNITS{`CCA_RST_PIN}}; // idle high, avoids a false edge
			sync2_r <= {NUM_UNITS{`CCA_RST_PIN}};
			sync3_r <= {NUM_UNITS{`CCA_RST_PIN}};
			lvl_r   <= {NUM_UNITS{`CCA_RST_PIN}};
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			lvl_r   <= (sync2_r & sync3_r) | (lvl_r & (sync2_r | sync3_r));
		end
	end

	// *********************************************
	// shared counter
	// *********************************************
	// a software write beats a count in the same cycle
	always @(posedge clock) begin
		if (rst) begin
			cnt_r  <= {`CCA_RST_BYTE, `CCA_RST_BYTE};
			step_r <= 1'b0;
			wrap_r <= 1'b0;
		end else begin
			step_r <= advance | wr_cntl | wr_cnth;
			wrap_r <= advance & (cnt_r[7:0] == `CCA_CNTL_MAX);
			if (wr_cntl)
				cnt_r[7:0] <= sfr_wdata;
			else if (wr_cnth)
				cnt_r[15:8] <= sfr_wdata;
			else if (advance)
				cnt_r <= cnt_r + 16'h0001;
		end
	end

	// *********************************************
	// array control and mode registers
	// *********************************************
	// overflow flag: hardware set wins over software write
	always @(posedge clock) begin
		if (rst) begin
			ovf_r   <= 1'b0;
			run_r   <= 1'b0;
			amode_r <= `CCA_RST_BYTE;
		end else begin
			if (advance & full)
				ovf_r <= 1'b1;
			else if (wr_ctrl)
				ovf_r <= sfr_wdata[`CCA_CTRL_OVF];
			if (wr_ctrl)
				run_r <= sfr_wdata[`CCA_CTRL_RUN];
			if (wr_amode)
				amode_r <= sfr_wdata & `CCA_AMODE_MASK;
		end
	end

	// *********************************************
	// compare/capture modules
	// *********************************************
	genvar gi;
	generate
		for (gi = 0; gi < NUM_UNITS; gi = gi + 1) begin : g_unit
			localparam [7:0] IDX = gi;
			// every unit sees the same counter and wrap pulse
			cca_unit u_unit (
				.clock      (clock),
				.rst        (rst),
				.wdata      (sfr_wdata),
				.wr_mode    (sfr_wr & is_slot(sfr_addr, `CCA_ADDR_MODE0, IDX)),
				.wr_low     (sfr_wr & is_slot(sfr_addr, `CCA_ADDR_CMPL0, IDX)),
				.wr_high    (sfr_wr & is_slot(sfr_addr, `CCA_ADDR_CMPH0, IDX)),
				.wr_flag    (wr_ctrl),
				.flag_d     (sfr_wdata[gi]),
				.cnt        (cnt_r),
				.step       (step_r),
				.wrap       (wrap_r),
				.pin_lvl    (lvl_r[gi]),
				.mode_r     (mode_all[gi*7 +: 7]),
				.cmp_low_r  (cmpl_all[gi*8 +: 8]),
				.cmp_high_r (cmph_all[gi*8 +: 8]),
				.flag_r     (flag_all[gi]),
				.pin_out_r  (out_all[gi]),
				.pin_oe_n_r (oe_n_all[gi]),
				.hit        (hit_all[gi])
			);
			assign irq_en_all[gi] = mode_all[gi*7 + `CCA_MODE_IRQ];
		end
	endgenerate

	// *********************************************
	// pins, interrupt and watchdog
	// *********************************************
	// retimed so every top output comes from a local flop
	always @(posedge clock) begin
		if (rst) begin
			pin_out_r    <= {NUM_UNITS{`CCA_RST_PIN}};
			pin_oe_n_r   <= {NUM_UNITS{1'b1}};
			irq_r        <= 1'b0;
			wdog_reset_r <= 1'b0;
		end else begin
			pin_out_r    <= out_all;
			pin_oe_n_r   <= oe_n_all;
			irq_r        <= (|(flag_all & irq_en_all)) |
			                (ovf_r & amode_r[`CCA_AMODE_OVFIE]);
			// internal reset request only; no external pin is driven
			wdog_reset_r <= hit_all[WDOG_UNIT] & amode_r[`CCA_AMODE_WDOG];
		end
	end

	// *********************************************
	// register read
	// *********************************************
	// unmapped addresses read as zero; reserved bits read as zero
	always @* begin
		rd_nxt = 8'h00;
		off_rd = 8'h00;
		if (sfr_addr == `CCA_ADDR_CTRL) begin
			rd_nxt = {ovf_r, run_r, 6'h00};
			rd_nxt[NUM_UNITS-1:0] = flag_all;
		end else if (sfr_addr == `CCA_ADDR_AMODE) begin
			rd_nxt = amode_r;
		end else if (sfr_addr == `CCA_ADDR_CNTL) begin
			rd_nxt = cnt_r[7:0];
		end else if (sfr_addr == `CCA_ADDR_CNTH) begin
			rd_nxt = cnt_r[15:8];
		end else if (in_bank(sfr_addr, `CCA_ADDR_MODE0)) begin
			off_rd = sfr_addr - `CCA_ADDR_MODE0;
			rd_nxt = {1'b0, mode_all[off_rd*7 +: 7]};
		end else if (in_bank(sfr_addr, `CCA_ADDR_CMPL0)) begin
			off_rd = sfr_addr - `CCA_ADDR_CMPL0;
			rd_nxt = cmpl_all[off_rd*8 +: 8];
		end else if (in_bank(sfr_addr, `CCA_ADDR_CMPH0)) begin
			off_rd = sfr_addr - `CCA_ADDR_CMPH0;
			rd_nxt = cmph_all[off_rd*8 +: 8];
		end
	end

	// read data held until the next read strobe
	always @(posedge clock) begin
		if (rst) begin
			sfr_rdata_r <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata_r <= rd_nxt;
		end
	end
endmodule

//--- verif/cca_props.sv
`timescale 1ns/10ps
// ****
// port checks for the counter array
// ****
module cca_props #(
	parameter NUM_UNITS = 5
) (
	// clock and reset
	input wire                 clock,
	input wire                 rst,
	// register port and time base
	input wire [7:0]           sfr_addr,
	input wire [7:0]           sfr_wdata,
	input wire                 sfr_wr,
	input wire                 sfr_rd,
	input wire [7:0]           sfr_rdata_r,
	input wire                 count_tick,
	// outputs
	input wire [NUM_UNITS-1:0] pin_out_r,
	input wire [NUM_UNITS-1:0] pin_oe_n_r,
	input wire                 irq_r,
	input wire                 wdog_reset_r
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// recent tick or write; pin and watchdog outputs may only move shortly after one
	wire       chg = count_tick | sfr_wr;
	reg  [5:0] chg_h;
	always @(posedge clock)
		chg_h <= {chg_h[4:0], chg};
	sequence lo_wr; sfr_wr && sfr_addr == 8'he9; endsequence
	sequence lo_rd; sfr_rd && sfr_addr == 8'he9; endsequence

	rst_vals_a: assert property ($fell(rst) |-> sfr_rdata_r == 8'h00 && !irq_r
		&& !wdog_reset_r && &pin_oe_n_r && &pin_out_r) else $error("bad value after reset");
	rd_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata_r))
		else $error("read data moved without a read");
	unmap_rd_a: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata_r == 8'h00)
		else $error("unmapped read not zero");
	mode_rsv_a: assert property (sfr_rd && sfr_addr inside {[8'hda:8'hde]}
		|=> !sfr_rdata_r[7]) else $error("mode bit 7 reads one");
	cnt_back_a: assert property (lo_wr ##1 !count_tick ##1 lo_rd
		|=> sfr_rdata_r == $past(sfr_wdata, 3)) else $error("counter low lost write");
	wdog_pulse_a: assert property ($rose(wdog_reset_r) |=> !wdog_reset_r)
		else $error("watchdog request longer than one cycle");
	wdog_cause_a: assert property (wdog_reset_r |-> |chg_h)
		else $error("watchdog request without counter change");
	pin_cause_a: assert property ($changed(pin_out_r) |-> |chg_h)
		else $error("pin output moved without cause");
	oe_cause_a: assert property ($changed(pin_oe_n_r) |-> |chg_h)
		else $error("pin enable moved without a write");
endmodule

//--- verif/cca_pins.sv
`timescale 1ns/10ps
// ****
// far side of the module pins
// ****
module cca_pins (
	// design drive
	input  wire [4:0] pin_out_r,
	input  wire [4:0] pin_oe_n_r,
	// far-side drive
	input  wire [4:0] ext_en,
	input  wire [4:0] ext_val,
	// resolved level
	output wire [4:0] pin_lvl
);
	// pull-up wins where nobody drives, so a released pin never keeps a stale value
	assign pin_lvl = (~pin_oe_n_r & pin_out_r) | (pin_oe_n_r & ((ext_en & ext_val) | ~ext_en));
endmodule

//--- verif/cca_top_tb.sv
`timescale 1ns/10ps
// ****
// stimulus and checks
// ****
module cca_top_tb;
	// register port
	logic       clock      = 1'b0;
	logic       rst        = 1'b1;
	logic [7:0] sfr_addr   = 8'h00;
	logic [7:0] sfr_wdata  = 8'h00;
	logic       sfr_wr     = 1'b0;
	logic       sfr_rd     = 1'b0;
	logic       count_tick = 1'b0;
	wire  [7:0] sfr_rdata_r;
	// pins and requests
	logic [4:0] ext_val    = 5'h00;
	wire  [4:0] pin_lvl;
	wire  [4:0] pin_out_r;
	wire  [4:0] pin_oe_n_r;
	wire        irq_r;
	wire        wdog_reset_r;
	// bookkeeping
	int         n_fail     = 0;
	int         cmp_count  = 0;
	int         cyc        = 0;
	logic [7:0] wd_n       = 8'h00;

	always #20 clock = ~clock;

	cca_top #(.NUM_UNITS(5)) u_cca_top (.clock, .rst, .sfr_addr, .sfr_wdata, .sfr_wr,
		.sfr_rd, .sfr_rdata_r, .count_tick, .cpu_idle(1'b0), .pin_in(pin_lvl),
		.pin_out_r, .pin_oe_n_r, .irq_r, .wdog_reset_r);
	// only pin 3 is driven from outside; the rest sit on pull-ups
	cca_pins u_cca_pins (.pin_out_r, .pin_oe_n_r, .ext_en(5'h08), .ext_val, .pin_lvl);

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// strobe up for one taking edge, then one idle edge before the next request
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge clock);
		sfr_wr    <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge clock);
		sfr_rd   <= 1'b0;
		@(posedge clock);
		chk(sfr_rdata_r, exp);
	endtask
	// one tick, then room for match, flag, toggle and request to land
	task automatic tk();
		count_tick <= 1'b1;
		@(posedge clock);
		count_tick <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 20 && irq_r !== 1'b1; i++)
			@(posedge clock);
	endtask
	task automatic results();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// hang guard, far above the two hundred or so cycles the sequence needs
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			results();
		end
	end
	always @(posedge clock)
		if (wdog_reset_r === 1'b1)
			wd_n <= wd_n + 8'h01;

	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(8'he9, 8'h00);
		rd(8'hf9, 8'h00);
		rd(8'hea, 8'h00);
		rd(8'hfe, 8'h00);
		rd(8'h00, 8'h00);
		wr(8'he9, 8'hff);
		rd(8'he9, 8'hff);
		wr(8'hf9, 8'h12);
		rd(8'hf9, 8'h12);
		wr(8'hd8, 8'h40);
		tk();
		rd(8'he9, 8'h00);
		rd(8'hf9, 8'h13);
		wr(8'he9, 8'h3f);
		wr(8'hf9, 8'h12);
		// timer on module 0
		wr(8'hda, 8'hc9);
		rd(8'hda, 8'h49);
		wr(8'hea, 8'h40);
		rd(8'hda, 8'h09);
		wr(8'hfa, 8'h12);
		rd(8'hda, 8'h49);
		tk();
		rd(8'hd8, 8'h41);
		chk({7'h00, irq_r}, 8'h01);
		wr(8'hda, 8'h09);
		rd(8'hda, 8'h09);
		wr(8'hd8, 8'h40);
		rd(8'hd8, 8'h40);
		chk({7'h00, irq_r}, 8'h00);
		// toggle on module 1
		wr(8'heb, 8'h41);
		wr(8'hfb, 8'h12);
		wr(8'hdb, 8'h4c);
		tk();
		chk({3'h0, pin_out_r}, 8'h1d);
		chk({3'h0, pin_oe_n_r}, 8'h1d);
		wr(8'he9, 8'h40);
		tk();
		chk({3'h0, pin_out_r}, 8'h1f);
		// duty output on module 2
		wr(8'hec, 8'h80);
		wr(8'hdc, 8'h02);
		chk({3'h0, pin_oe_n_r}, 8'h1d);
		wr(8'hfc, 8'h80);
		rd(8'hdc, 8'h42);
		chk({3'h0, pin_out_r}, 8'h1b);
		chk({3'h0, pin_oe_n_r}, 8'h19);
		wr(8'he9, 8'h80);
		rd(8'he9, 8'h80);
		chk({3'h0, pin_out_r}, 8'h1f);
		wr(8'hfc, 8'h10);
		wr(8'he9, 8'hff);
		tk();
		rd(8'hec, 8'h10);
		chk({3'h0, pin_out_r}, 8'h1b);
		// capture on module 3, rising then falling
		wr(8'hdd, 8'h21);
		ext_val <= 5'h08;
		wait_irq();
		chk({7'h00, irq_r}, 8'h01);
		rd(8'hed, 8'h00);
		rd(8'hfd, 8'h13);
		rd(8'hd8, 8'h4a);
		wr(8'hd8, 8'h40);
		wr(8'hdd, 8'h11);
		wr(8'he9, 8'h55);
		ext_val <= 5'h00;
		wait_irq();
		chk({7'h00, irq_r}, 8'h01);
		rd(8'hed, 8'h55);
		rd(8'hfd, 8'h13);
		// watchdog on module 4: fire, disarm, rearm
		wr(8'hee, 8'h00);
		wr(8'hfe, 8'h14);
		wr(8'hde, 8'h40);
		for (int k = 0; k < 3; k++) begin
			wr(8'hd9, (k == 1) ? 8'h00 : 8'h40);
			wr(8'hf9, 8'h13);
			wr(8'he9, 8'hff);
			tk();
			rd(8'hd9, (k == 1) ? 8'h00 : 8'h40);
			// disarmed pass adds no pulse, rearmed pass adds one
			chk(wd_n, (k == 2) ? 8'h02 : 8'h01);
		end
		results();
	end
endmodule

bind cca_top cca_props #(.NUM_UNITS(NUM_UNITS)) u_cca_props (.clock, .rst, .sfr_addr,
	.sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata_r, .count_tick, .pin_out_r, .pin_oe_n_r,
	.irq_r, .wdog_reset_r);
